// ===== design/leif_top.sv
// Link error flags, async transmit guard and APB register slave
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "leif_cfg.svh"

// How it works
// - Bad first-word port enters bad-format state
// - Async FIFO underflow while a packet is open also enters bad-format
// - Bad-format blocks async until FIFO clear
// - Isochronous sending unaffected by bad-format
// - General receive FIFO overflow sets busy flag
// - After overflow, addressed packets get busy
// - Header CRC error sets flag, discards packet
// - Invalid transaction code sets its flag
// - Cycle beyond 125 us sets timeout flag
module leif_top #(
	parameter int CYCLE_CNT = `LEIF_CYCLE_CNT
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Async transmit FIFO write side
	input  wire logic        atf_write,
	input  wire logic        async_fifo_first_word_port_port,
	input  wire logic        atf_underflow,
	input  wire logic        atf_pkt_start,
	input  wire logic        atf_pkt_end,
	input  wire logic        tcode_valid,
	input  wire logic        tcode_invalid,
	output logic             async_tx_enable,
	output logic             atf_clear,
	// Isochronous transmit
	input  wire logic        iso_tx_req,
	output logic             iso_tx_enable,
	input  wire logic        cycle_start,
	input  wire logic        cycle_active,
	// Receiver
	input  wire logic        grf_overflow,
	input  wire logic        rx_hdr_done,
	input  wire logic        rx_addr_match,
	input  wire logic        rx_hdr_crc_bad,
	output logic             rx_send_busy,
	output logic             rx_discard,
	output logic             grf_clear,
	// Interrupt
	output logic             irq
);
	import leif_pkg::*;

	localparam int NF = `LEIF_NFLAGS;

	logic                 rst_s1_ff;   // Reset sync stage one
	logic                 rst_n;       // Synchronised reset
	leif_evt_if #(.N(NF)) ev ();       // Flag events
	leif_tx_state_t       tx_ff;       // Async transmitter state
	leif_tx_state_t       nxt_tx;
	logic [NF-1:0]        mask_ff;     // Interrupt mask
	logic [NF-1:0]        nxt_mask;
	logic                 ovf_ff;      // Receive FIFO overflowed
	logic                 nxt_ovf;
	logic [31:0]          prdata_ff;   // Read data
	logic [31:0]          nxt_prdata;
	logic                 async_fifo_clear_bit_ff;  // Clear pulses to FIFOs
	logic                 nxt_async_fifo_clear_bit;
	logic                 clr_grf_ff;
	logic                 nxt_clr_grf;
	logic                 busy_ff;     // Receive verdict outputs
	logic                 nxt_busy;
	logic                 disc_ff;
	logic                 nxt_disc;
	logic                 wr_acc;      // APB write strobe
	logic                 rd_acc;      // APB read capture, setup cycle
	logic                 bad_addr;    // Unmapped address
	logic                 timeout;     // Cycle overrun pulse
	leif_rx_verdict_t     verdict;     // Current receive choice

	// Reset released through two flops; asserts at once
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_ff <= 1'b0;
			rst_n     <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n     <= rst_s1_ff;
		end
	end

	// APB decode; answers with no wait states
	assign wr_acc   = psel && penable && pwrite;
	// Reads capture in the setup cycle so data stands at the access edge
	assign rd_acc   = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign bad_addr = !(paddr == `LEIF_OFS_STATUS ||
	                    paddr == `LEIF_OFS_MASK ||
	                    paddr == `LEIF_OFS_CONTROL ||
	                    paddr == `LEIF_OFS_STATE);
	assign pslverr  = psel && penable && bad_addr;
	assign prdata   = prdata_ff;

	// Sticky flag storage
	leif_flag_bank u_flags (
		.clk   (clk),
		.rst_n (rst_n),
		.ev    (ev.bank)
	);

	// Cycle length watchdog
	leif_cycle_timer #(.LIMIT(CYCLE_CNT)) u_cyc (
		.clk          (clk),
		.rst_n        (rst_n),
		.cycle_start  (cycle_start),
		.cycle_active (cycle_active),
		.overrun      (timeout)
	);

	// Receive verdict; CRC failure outranks busy
	always_comb begin
		verdict = LEIF_RX_ACCEPT;
		if (rx_hdr_done && rx_hdr_crc_bad) begin
			verdict = LEIF_RX_DISCARD;
		end else if (rx_hdr_done && rx_addr_match && ovf_ff) begin
			verdict = LEIF_RX_BUSY;
		end
	end

	// Event pulses into the sticky bank
	always_comb begin
		ev.set = '0;
		ev.set[`LEIF_BIT_ATBAD] = (atf_write && atf_pkt_start &&
		                           !async_fifo_first_word_port_port) ||
		                          (atf_underflow && tx_ff == LEIF_TX_PACKET);
		ev.set[`LEIF_BIT_BUSY]  = grf_overflow;
		ev.set[`LEIF_BIT_HDR]   = rx_hdr_done && rx_hdr_crc_bad;
		ev.set[`LEIF_BIT_TCODE] = tcode_valid && tcode_invalid;
		ev.set[`LEIF_BIT_CYTMO] = timeout;
		ev.clr = '0;
		if (wr_acc && paddr == `LEIF_OFS_STATUS) begin
			ev.clr = pwdata[NF-1:0];
		end
	end

	// Async transmitter state and register next values
	always_comb begin
		nxt_tx      = tx_ff;
		nxt_mask    = mask_ff;
		nxt_ovf     = ovf_ff || grf_overflow;
		nxt_async_fifo_clear_bit = 1'b0;
		nxt_clr_grf = 1'b0;
		nxt_busy    = (verdict == LEIF_RX_BUSY);
		nxt_disc    = (verdict == LEIF_RX_DISCARD);
		nxt_prdata  = prdata_ff;
		case (tx_ff)
			LEIF_TX_IDLE: begin
				if (atf_write && atf_pkt_start) begin
					nxt_tx = async_fifo_first_word_port_port ? LEIF_TX_PACKET
					                        : LEIF_TX_BADFMT;
				end
			end
			LEIF_TX_PACKET: begin
				if (atf_underflow || (atf_write && atf_pkt_start &&
				                      !async_fifo_first_word_port_port)) begin
					nxt_tx = LEIF_TX_BADFMT;
				end else if (atf_pkt_end) begin
					nxt_tx = LEIF_TX_IDLE;
				end
			end
			LEIF_TX_BADFMT: begin
				// Only the FIFO clear brings it back
				nxt_tx = LEIF_TX_BADFMT;
			end
			default: begin
				nxt_tx = LEIF_TX_IDLE;
			end
		endcase
		// Register writes
		if (wr_acc && paddr == `LEIF_OFS_MASK) begin
			nxt_mask = pwdata[NF-1:0];
		end
		if (wr_acc && paddr == `LEIF_OFS_CONTROL) begin
			if (pwdata[`LEIF_BIT_ASYNC_FIFO_CLEAR_BIT]) begin
				nxt_async_fifo_clear_bit = 1'b1;
				nxt_tx      = LEIF_TX_IDLE;
			end
			// Receive FIFO clear also ends overflow busy
			if (pwdata[`LEIF_BIT_CLR_GRF]) begin
				nxt_clr_grf = 1'b1;
				nxt_ovf     = grf_overflow;
			end
		end
		// Register reads, unmapped reads give zero
		if (rd_acc) begin
			case (paddr)
				`LEIF_OFS_STATUS:  nxt_prdata = {{(32-NF){1'b0}}, ev.flags};
				`LEIF_OFS_MASK:    nxt_prdata = {{(32-NF){1'b0}}, mask_ff};
				`LEIF_OFS_CONTROL: nxt_prdata = 32'h00000000;
				`LEIF_OFS_STATE: begin
					nxt_prdata = {29'h00000000, ovf_ff,
					              tx_ff == LEIF_TX_BADFMT,
					              tx_ff == LEIF_TX_PACKET};
				end
				default:           nxt_prdata = 32'h00000000;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ff      <= LEIF_TX_IDLE;
			mask_ff    <= `LEIF_RST_MASK;
			ovf_ff     <= 1'b0;
			async_fifo_clear_bit_ff <= 1'b0;
			clr_grf_ff <= 1'b0;
			busy_ff    <= 1'b0;
			disc_ff    <= 1'b0;
			prdata_ff  <= 32'h00000000;
			irq        <= 1'b0;
		end else begin
			tx_ff      <= nxt_tx;
			mask_ff    <= nxt_mask;
			ovf_ff     <= nxt_ovf;
			async_fifo_clear_bit_ff <= nxt_async_fifo_clear_bit;
			clr_grf_ff <= nxt_clr_grf;
			busy_ff    <= nxt_busy;
			disc_ff    <= nxt_disc;
			prdata_ff  <= nxt_prdata;
			irq        <= |(ev.flags & mask_ff);
		end
	end

	assign async_tx_enable = (tx_ff != LEIF_TX_BADFMT) && !async_fifo_clear_bit_ff;
	assign iso_tx_enable   = iso_tx_req;
	assign atf_clear       = async_fifo_clear_bit_ff;
	assign grf_clear       = clr_grf_ff;
	assign rx_send_busy    = busy_ff;
	assign rx_discard      = disc_ff;
endmodule : leif_top

// ===== common/leif_cfg.svh
// Register offsets, bit positions and timing counts of the link error flags
`ifndef LEIF_CFG_SVH
`define LEIF_CFG_SVH

// Register byte offsets
`define LEIF_OFS_STATUS   12'h000
`define LEIF_OFS_MASK     12'h004
`define LEIF_OFS_CONTROL  12'h008
`define LEIF_OFS_STATE    12'h00C

// Flag bit positions, shared by status and mask
`define LEIF_BIT_ATBAD    0
`define LEIF_BIT_BUSY     1
`define LEIF_BIT_HDR      2
`define LEIF_BIT_TCODE    3
`define LEIF_BIT_CYTMO    4
`define LEIF_NFLAGS       5

// Control bit positions
`define LEIF_BIT_ASYNC_FIFO_CLEAR_BIT  0
`define LEIF_BIT_CLR_GRF  1

// Reset values
`define LEIF_RST_MASK     5'h00

// Cycle timeout: 125 us at 50 ns per clock, longest time rounds down
`define LEIF_CYCLE_US     125
`define LEIF_CLK_NS       50
`define LEIF_CYCLE_CNT    ((`LEIF_CYCLE_US * 1000) / `LEIF_CLK_NS)

`endif

// ===== common/leif_pkg.sv
// Types shared by the link error flag block
package leif_pkg;
	// Asynchronous transmitter state
	typedef enum logic [1:0] {
		LEIF_TX_IDLE,
		LEIF_TX_PACKET,
		LEIF_TX_BADFMT
	} leif_tx_state_t;

	// Receive decision for one incoming header
	typedef enum logic [1:0] {
		LEIF_RX_ACCEPT,
		LEIF_RX_BUSY,
		LEIF_RX_DISCARD
	} leif_rx_verdict_t;
endpackage : leif_pkg

// ===== common/leif_evt_if.sv
// Event carrier between the flag bank and its users
`timescale 1ns/1ns
interface leif_evt_if #(parameter int N = 5);
	logic [N-1:0] set;   // One-cycle event pulses
	logic [N-1:0] clr;   // Write-one-to-clear pulses
	logic [N-1:0] flags; // Sticky flag levels
	modport src  (output set, output clr, input flags);
	modport bank (input set, input clr, output flags);
endinterface : leif_evt_if

// ===== design/leif_flag_bank.sv
// Sticky flag bank, set wins over clear
`timescale 1ns/1ns
module leif_flag_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Events
	leif_evt_if.bank ev
);
	logic [$bits(ev.flags)-1:0] flags_ff;     // Held flags
	logic [$bits(ev.flags)-1:0] nxt_flags;    // Next flags

	// Set beats a clear in the same cycle so no event is lost
	always_comb begin
		nxt_flags = (flags_ff & ~ev.clr) | ev.set;
	end

	// Register the flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	assign ev.flags = flags_ff;
endmodule : leif_flag_bank

// ===== design/leif_cycle_timer.sv
// Isochronous cycle length watchdog
`timescale 1ns/1ns
`include "leif_cfg.svh"
module leif_cycle_timer #(
	parameter int LIMIT = `LEIF_CYCLE_CNT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Cycle activity
	input wire logic cycle_start,
	input wire logic cycle_active,
	// One-cycle overrun pulse
	output logic     overrun
);
	logic [$clog2(LIMIT+1)-1:0] cnt_ff;   // Cycles since start
	logic [$clog2(LIMIT+1)-1:0] nxt_cnt;  // Next count
	logic                       fired_ff; // Already reported
	logic                       nxt_fired;
	logic                       hit;      // Limit just passed

	// Count while active; saturate so one cycle reports once
	always_comb begin
		nxt_cnt   = cnt_ff;
		nxt_fired = fired_ff;
		hit       = 1'b0;
		if (cycle_start) begin
			nxt_cnt   = '0;
			nxt_fired = 1'b0;
		end else if (cycle_active) begin
			if (cnt_ff < ($clog2(LIMIT+1))'(LIMIT)) begin
				nxt_cnt = cnt_ff + 1'b1;
			end else if (!fired_ff) begin
				// Lasted longer than the limit
				hit       = 1'b1;
				nxt_fired = 1'b1;
			end
		end else begin
			nxt_cnt = '0;
		end
	end

	// Register count and latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff   <= '0;
			fired_ff <= 1'b0;
			overrun  <= 1'b0;
		end else begin
			cnt_ff   <= nxt_cnt;
			fired_ff <= nxt_fired;
			overrun  <= hit;
		end
	end
endmodule : leif_cycle_timer

// ===== test/leif_top_sva.sv
// Assertion checker for the link error flag block
`timescale 1ns/1ns
module leif_top_sva #(
	parameter int CYCLE_CNT = 20
) (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	// Transmit side
	input wire logic        atf_write,
	input wire logic        async_fifo_first_word_port_port,
	input wire logic        atf_pkt_start,
	input wire logic        async_tx_enable,
	input wire logic        atf_clear,
	input wire logic        iso_tx_req,
	input wire logic        iso_tx_enable,
	// Receive side
	input wire logic        rx_hdr_done,
	input wire logic        rx_hdr_crc_bad,
	input wire logic        rx_send_busy,
	input wire logic        rx_discard,
	input wire logic        grf_clear
);
	logic wctl; // Host write of the async clear bit
	assign wctl = psel && penable && pwrite && paddr == 12'h008 && pwdata[0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_bad_first: assert property (
		atf_write && atf_pkt_start && !async_fifo_first_word_port_port |=> !async_tx_enable)
		else $error("async not blocked after bad first word");
	chk_clr_pulse: assert property (
		wctl |=> atf_clear && !async_tx_enable)
		else $error("clear bit gave no clear pulse");
	chk_clr_cause: assert property (
		atf_clear |-> $past(wctl)) else $error("stray async clear");
	chk_unblock_src: assert property (
		$rose(async_tx_enable) |-> $past(atf_clear))
		else $error("async reopened without clear");
	chk_iso_free: assert property (
		iso_tx_enable == iso_tx_req) else $error("iso send disturbed");
	chk_busy_cause: assert property (
		rx_send_busy |-> $past(rx_hdr_done && !rx_hdr_crc_bad))
		else $error("busy ack without good header");
	chk_grf_pulse: assert property (
		psel && penable && pwrite && paddr == 12'h008 && pwdata[1]
		|=> grf_clear) else $error("receive clear not pulsed");
	chk_crc_drop: assert property (
		rx_hdr_done && rx_hdr_crc_bad |=> rx_discard && !rx_send_busy)
		else $error("bad header not discarded");
	chk_unmapped_err: assert property (
		psel && penable && paddr[11:4] != 8'h00 |-> pslverr)
		else $error("no error on unmapped access");
endmodule : leif_top_sva

bind leif_top leif_top_sva #(.CYCLE_CNT(CYCLE_CNT)) u_sva (
	.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.atf_write(atf_write), .async_fifo_first_word_port_port(async_fifo_first_word_port_port),
	.atf_pkt_start(atf_pkt_start), .async_tx_enable(async_tx_enable),
	.atf_clear(atf_clear), .iso_tx_req(iso_tx_req),
	.iso_tx_enable(iso_tx_enable), .rx_hdr_done(rx_hdr_done),
	.rx_hdr_crc_bad(rx_hdr_crc_bad), .rx_send_busy(rx_send_busy),
	.rx_discard(rx_discard), .grf_clear(grf_clear));

// ===== test/leif_apb_host.sv
// Host model issuing APB register accesses
`timescale 1ns/1ns
module leif_apb_host (
	// Clock
	input  wire logic        clk,
	// APB master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	// Read result, one-cycle pulse
	output logic             rd_vld,
	output logic [31:0]      rd_data
);
	initial begin
		{psel, penable, pwrite, rd_vld} = 4'h0;
		{paddr, pwdata, rd_data} = '0;
	end
	// One transfer, held until pready is seen at an edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel    <= 1'b0;
		penable <= 1'b0;
		// Released data must not keep showing the old value
		pwdata  <= ~d;
		// Read data is taken at the edge that sees pready
		if (!w) begin
			rd_data <= prdata;
			rd_vld  <= 1'b1;
			@(posedge clk);
			rd_vld  <= 1'b0;
		end
	endtask : xfer
endmodule : leif_apb_host

// ===== test/leif_top_tb_top.sv
// Self-checking bench for the link error flag block
`timescale 1ns/1ns
module leif_top_tb_top;
	logic clk, resetn, iso_req, cyc_act, rd_vld, busy, disc, ena;
	logic psel, penable, pwrite, pready, irq, iso_en;
	logic [11:0] paddr, ev_s; // ev_s bits drive the event inputs
	logic [31:0] pwdata, prdata, rd_data, r;
	logic [31:0] exp_q[$];    // Expected read results, oldest first
	int n_fail, samples_checked, seed, cyc, i;
	leif_top #(.CYCLE_CNT(20)) u_dut (.clk(clk), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
		.atf_write(ev_s[0]), .async_fifo_first_word_port_port(ev_s[1]),
		.atf_underflow(ev_s[2]), .atf_pkt_start(ev_s[3]),
		.atf_pkt_end(ev_s[4]), .tcode_valid(ev_s[5]),
		.tcode_invalid(ev_s[6]), .async_tx_enable(ena), .atf_clear(),
		.iso_tx_req(iso_req), .iso_tx_enable(iso_en),
		.cycle_start(ev_s[11]), .cycle_active(cyc_act),
		.grf_overflow(ev_s[7]), .rx_hdr_done(ev_s[8]),
		.rx_addr_match(ev_s[9]), .rx_hdr_crc_bad(ev_s[10]),
		.rx_send_busy(busy), .rx_discard(disc), .grf_clear(), .irq(irq));
	leif_apb_host u_host (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .rd_vld(rd_vld), .rd_data(rd_data));
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, 32'h0);
	endtask : rd
	// One-cycle burst on the event inputs
	task ev(input logic [11:0] v);
		@(posedge clk);
		ev_s <= v;
		@(posedge clk);
		ev_s <= 12'h000;
		#1;
	endtask : ev
	task results;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	// Compare each read result with its oldest note
	always @(posedge clk) if (rd_vld === 1'b1) chk("read", rd_data,
		exp_q.pop_front());
	// Hang guard
	always @(posedge clk) if (++cyc > 3000) begin
		n_fail++;
		results();
	end
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		{resetn, iso_req, cyc_act, ev_s, seed, cyc} = '0;
		seed = 17361;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 5; i++) rd(12'(i * 4), 32'h0); // Reset and unmapped
		r = $random(seed);
		u_host.xfer(1'b1, 12'h004, r);
		rd(12'h004, {27'h0, r[4:0]});
		u_host.xfer(1'b1, 12'h004, 32'h0000001F);
		$display("T1 registers done");
		ev(12'h080);
		ev(12'h300);
		chk("busy", busy, 1);
		chk("irq", irq, 1);
		ev(12'h100);
		chk("busy", busy, 0);
		ev(12'h700);
		chk("discard", disc, 1);
		rd(12'h000, 32'h00000006);
		u_host.xfer(1'b1, 12'h008, 32'h00000002);
		ev(12'h300);
		chk("busy", busy, 0);
		ev(12'h060);
		$display("T2 receive done");
		iso_req <= 1'b1;
		ev(12'h009);
		chk("enable", ena, 0);
		chk("iso", iso_en, 1);
		rd(12'h000, 32'h0000000F);
		// host clears the async FIFO to resume
		u_host.xfer(1'b1, 12'h008, 32'h00000001);
		#1 chk("enable", ena, 0);
		@(posedge clk);
		#1 chk("enable", ena, 1);
		u_host.xfer(1'b1, 12'h000, 32'h00000001);
		rd(12'h000, 32'h0000000E);
		ev(12'h00B);
		ev(12'h004);
		chk("enable", ena, 0);
		rd(12'h000, 32'h0000000F);
		u_host.xfer(1'b1, 12'h008, 32'h00000001);
		// Bad first word while a packet is open
		ev(12'h00B);
		ev(12'h009);
		chk("enable", ena, 0);
		u_host.xfer(1'b1, 12'h008, 32'h00000001);
		$display("T3 transmit done");
		cyc_act <= 1'b1;
		ev(12'h800);
		// Capture lands one cycle before the overrun flag
		repeat (19) @(posedge clk);
		rd(12'h000, 32'h0000000F);
		cyc_act <= 1'b0;
		rd(12'h000, 32'h0000001F);
		rd(12'h000, 32'h0000001F);
		u_host.xfer(1'b1, 12'h000, 32'h0000001F);
		rd(12'h000, 32'h0);
		chk("irq", irq, 0);
		$display("T4 timeout and clear done");
		results();
	end
endmodule : leif_top_tb_top
